// >>> design/boot_rom_strap_and_fpu_error.sv
`timescale 1ns/1ps
module boot_rom_strap_and_fpu_error (
    input  wire logic                              clk,
    input  wire logic                              resetn,
    input  wire logic                              gateA20In,
    input  wire logic                              gateA20Level,
    output logic                                   gateA20Out,
    output logic                                   gateA20Oe,
    input  wire logic                              bootRomSelectIn,
    input  wire logic                              bootRomSelectLevel,
    output logic                                   bootRomSelectOut,
    output logic                                   bootRomSelectOe,
    input  wire logic                              ignoreNumericErrorIn,
    input  wire logic                              ignoreNumericErrorLevel,
    output logic                                   ignoreNumericErrorOut,
    output logic                                   ignoreNumericErrorOe,
    input  wire logic                              floatErrorIn,
    output logic                                   irq13,
    input  wire logic [strap_pkg::ROM_ADDR_W-1:0]  romAddrIn,
    output logic [strap_pkg::ROM_ADDR_W-1:0]       romAddrOut,
    output logic                                   strapsValid
);
    // Strap latch
    logic                                  latched;
    logic                                  next_latched;
    logic                                  romModeStrap;
    logic                                  next_romModeStrap;
    logic                                  recoveryStrapA;
    logic                                  next_recoveryStrapA;
    logic                                  recoveryStrapB;
    logic                                  next_recoveryStrapB;

    // Processor side
    logic                                  ignoreLevel;
    logic                                  next_ignoreLevel;
    logic                                  irqLevel;
    logic                                  next_irqLevel;

    // Boot ROM address path
    logic [strap_pkg::ROM_ADDR_W-1:0]      mask;
    logic [strap_pkg::ROM_ADDR_W-1:0]      activeMask;
    logic [strap_pkg::ROM_ADDR_W-1:0]      romAddr;
    logic [strap_pkg::ROM_ADDR_W-1:0]      next_romAddr;

    strap_decode u_decode (
        .rom_mode_strap    (romModeStrap),
        .strapA     (recoveryStrapA),
        .strapB     (recoveryStrapB),
        .invertMask (mask)
    );

    always_comb begin
        next_latched        = 1'b1;
        next_romModeStrap   = romModeStrap;
        next_recoveryStrapA = recoveryStrapA;
        next_recoveryStrapB = recoveryStrapB;
        // Sampled on the first edge after reset release, then frozen
        if (!latched) begin // [R10]
            next_romModeStrap   = bootRomSelectIn;      // [R02]
            next_recoveryStrapA = gateA20In;            // [R02]
            next_recoveryStrapB = ignoreNumericErrorIn; // [R01]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latched        <= 1'b0;
            // Mode reads high until sampled, so nothing is inverted early
            romModeStrap   <= 1'b1;
            recoveryStrapA <= 1'b0;
            recoveryStrapB <= 1'b0;
        end else begin
            latched        <= next_latched;
            romModeStrap   <= next_romModeStrap;
            recoveryStrapA <= next_recoveryStrapA;
            recoveryStrapB <= next_recoveryStrapB;
        end
    end

    always_comb begin
        // Held quiet until the shared pins have been turned around
        next_ignoreLevel = latched & ignoreNumericErrorLevel; // [R08]
        next_irqLevel    = latched & floatErrorIn;            // [R09]
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ignoreLevel <= 1'b0;
            irqLevel    <= 1'b0;
        end else begin
            ignoreLevel <= next_ignoreLevel;
            irqLevel    <= next_irqLevel;
        end
    end

    always_comb begin
        // Straps not yet known: the address passes uninverted
        activeMask   = latched ? mask : strap_pkg::NO_INVERT; // [R10]
        next_romAddr = romAddrIn ^ activeMask;                // [R03]
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            romAddr <= strap_pkg::NO_INVERT;
        end else begin
            romAddr <= next_romAddr;
        end
    end

    // Pins released while straps are read so pull resistors set them
    assign gateA20Oe             = latched; // [R02]
    assign gateA20Out            = gateA20Level;
    assign bootRomSelectOe       = latched; // [R02]
    assign bootRomSelectOut      = bootRomSelectLevel;
    assign ignoreNumericErrorOe  = latched; // [R08]
    assign ignoreNumericErrorOut = ignoreLevel;
    assign irq13                 = irqLevel;
    assign romAddrOut            = romAddr;
    assign strapsValid           = latched;

    sequence ferrSeen;
        latched && floatErrorIn;
    endsequence

    sequence awaitingStraps;
        !latched;
    endsequence

    sequence strapsTaken;
        latched && recoveryStrapA == $past(gateA20In) && recoveryStrapB == $past(ignoreNumericErrorIn)
            && romModeStrap == $past(bootRomSelectIn);
    endsequence

    straps_frozen_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(latched) |-> $stable(romModeStrap) && $stable(recoveryStrapA) && $stable(recoveryStrapB)) // [R10]
        else $error("straps changed after latching");

    mask_frozen_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(latched) |-> $stable(mask)) // [R10]
        else $error("invert mask changed after latching");

    latch_holds_a: assert property (@(posedge clk) disable iff (!resetn)
        latched |=> latched) // [R10]
        else $error("straps valid dropped without reset");

    strap_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        awaitingStraps |=> strapsTaken) // [R01]
        else $error("strap capture wrong");

    pins_released_a: assert property (@(posedge clk) disable iff (!resetn)
        awaitingStraps |-> !gateA20Oe && !bootRomSelectOe && !ignoreNumericErrorOe) // [R02]
        else $error("strap pin driven while straps are read");

    pin_drive_a: assert property (@(posedge clk) disable iff (!resetn)
        latched |-> gateA20Out == gateA20Level && bootRomSelectOut == bootRomSelectLevel) // [R02]
        else $error("shared pin not driven with its level");

    quiet_early_a: assert property (@(posedge clk) disable iff (!resetn)
        awaitingStraps |=> !irq13 && !ignoreNumericErrorOut) // [R10]
        else $error("processor side active before straps latched");

    release_pass_a: assert property (@(posedge clk) disable iff (!resetn)
        awaitingStraps |=> romAddrOut == $past(romAddrIn)) // [R10]
        else $error("address inverted before straps latched");

    mode_high_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && romModeStrap |-> mask == strap_pkg::NO_INVERT) // [R03]
        else $error("mask nonzero in mode high");

    mode_pass_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && $past(latched) && romModeStrap |-> romAddrOut == $past(romAddrIn)) // [R03]
        else $error("address altered in mode high");

    addr_path_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) |-> romAddrOut
            == ($past(romAddrIn) ^ ($past(latched) ? $past(mask) : strap_pkg::NO_INVERT))) // [R03]
        else $error("boot ROM address path wrong");

    invert_bit16_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && !romModeStrap && recoveryStrapA && recoveryStrapB |-> mask == 20'h10000) // [R04]
        else $error("bit 16 not inverted");

    invert_bit17_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && !romModeStrap && recoveryStrapA && !recoveryStrapB |-> mask == 20'h20000) // [R05]
        else $error("bit 17 not inverted");

    invert_bit18_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && !romModeStrap && !recoveryStrapA && recoveryStrapB |-> mask == 20'h40000) // [R06]
        else $error("bit 18 not inverted");

    invert_bit15_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && !romModeStrap && !recoveryStrapA && !recoveryStrapB |-> mask == 20'h08000) // [R07]
        else $error("bit 15 not inverted");

    mask_onehot_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && !romModeStrap |-> $onehot(mask)) // [R04]
        else $error("mode low must invert exactly one bit");

    irq_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        ferrSeen |=> irq13) // [R09]
        else $error("irq13 missed float error");

    irq_drop_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && !floatErrorIn |=> !irq13) // [R09]
        else $error("irq13 raised without float error");

    irq_level_a: assert property (@(posedge clk) disable iff (!resetn)
        irq13 == ($past(latched) && $past(floatErrorIn))) // [R09]
        else $error("irq13 level wrong");

    ign_drive_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && ignoreNumericErrorLevel |=> ignoreNumericErrorOe && ignoreNumericErrorOut) // [R08]
        else $error("ignore numeric error not driven");

    ign_release_a: assert property (@(posedge clk) disable iff (!resetn)
        latched && !ignoreNumericErrorLevel |=> !ignoreNumericErrorOut) // [R08]
        else $error("ignore numeric error stuck high");

    ign_level_a: assert property (@(posedge clk) disable iff (!resetn)
        ignoreNumericErrorOut == ($past(latched) && $past(ignoreNumericErrorLevel))) // [R08]
        else $error("ignore numeric error level wrong");

    valid_oe_a: assert property (@(posedge clk) disable iff (!resetn)
        strapsValid |-> gateA20Oe && bootRomSelectOe && ignoreNumericErrorOe) // [R08]
        else $error("pin not driven after straps latched");
endmodule

// >>> common/strap_pkg.sv
// Overview of operation
// R01: Ignore-numeric-error pin is read as the second recovery strap at power-up.
// R02: First recovery strap from gate-A20 pin; ROM mode strap from ROM select pin.
// R03: ROM mode strap high: no boot ROM address bit inverted.
// R04: Mode low, both recovery straps high: invert address bit 16.
// R05: Mode low, strap A high, strap B low: invert address bit 17.
// R06: Mode low, strap A low, strap B high: invert address bit 18.
// R07: Mode and both recovery straps low: invert address bit 15.
// R08: After power-up drive ignore-numeric-error to the processor.
// R09: Floating-point error input raises interrupt request 13.
// R10: Straps latched once at end of reset, held until next reset.
package strap_pkg;
    localparam int ROM_ADDR_W = 20;
    localparam int BIT_16KB   = 16;
    localparam int BIT_32KB   = 17;
    localparam int BIT_64KB   = 18;
    localparam int BIT_8KB    = 15;
    localparam logic [ROM_ADDR_W-1:0] NO_INVERT = 20'h00000;
endpackage

// >>> design/strap_decode.sv
`timescale 1ns/1ps
module strap_decode (
    input  wire logic                              rom_mode_strap,
    input  wire logic                              strapA,
    input  wire logic                              strapB,
    output logic [strap_pkg::ROM_ADDR_W-1:0]       invertMask
);
    always_comb begin
        invertMask = strap_pkg::NO_INVERT;
        if (!rom_mode_strap) begin
            unique case ({strapA, strapB})
                2'b11: invertMask[strap_pkg::BIT_16KB] = 1'b1; // [R04]
                2'b10: invertMask[strap_pkg::BIT_32KB] = 1'b1; // [R05]
                2'b01: invertMask[strap_pkg::BIT_64KB] = 1'b1; // [R06]
                2'b00: invertMask[strap_pkg::BIT_8KB]  = 1'b1; // [R07]
            endcase
        end
        // Mode strap high leaves the mask clear [R03]
    end
endmodule

// >>> tb/strap_board.sv
`timescale 1ns/1ps
module strap_board (
    input  wire logic strapA,
    input  wire logic strapB,
    input  wire logic rom_mode_strap,
    input  wire logic a20Out,
    input  wire logic a20Oe,
    input  wire logic romOut,
    input  wire logic romOe,
    input  wire logic ignOut,
    input  wire logic ignOe,
    output logic      a20Pin,
    output logic      romPin,
    output logic      ignPin
);
    // Pull resistors win only while the chip is not driving
    assign a20Pin = a20Oe ? a20Out : strapA;
    assign romPin = romOe ? romOut : rom_mode_strap;
    assign ignPin = ignOe ? ignOut : strapB;
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, resetn = 0, sA = 1, sB = 1, sM = 1, float_error_in = 0, ignLvl = 0, a20Lvl = 0, romLvl = 0;
    logic [19:0] addr = 20'h00000;
    logic [19:0] mask;
    logic [27:0] note;
    logic [27:0] notes[$];
    wire a20Pin, romPin, ignPin, a20Out, a20Oe, romOut, romOe, ignOut, ignOe, irq, valid;
    wire [19:0] addrOut;
    int n_errors = 0, comparisons = 0, cycles = 0;
    initial forever #10 clk = ~clk;
    boot_rom_strap_and_fpu_error u_dut (.clk(clk), .resetn(resetn), .gateA20In(a20Pin), .gateA20Level(a20Lvl),
        .gateA20Out(a20Out), .gateA20Oe(a20Oe), .bootRomSelectIn(romPin), .bootRomSelectLevel(romLvl),
        .bootRomSelectOut(romOut), .bootRomSelectOe(romOe), .ignoreNumericErrorIn(ignPin),
        .ignoreNumericErrorLevel(ignLvl), .ignoreNumericErrorOut(ignOut), .ignoreNumericErrorOe(ignOe),
        .floatErrorIn(float_error_in), .irq13(irq), .romAddrIn(addr), .romAddrOut(addrOut), .strapsValid(valid));
    strap_board u_board (.strapA(sA), .strapB(sB), .rom_mode_strap(sM), .a20Out(a20Out), .a20Oe(a20Oe),
        .romOut(romOut), .romOe(romOe), .ignOut(ignOut), .ignOe(ignOe), .a20Pin(a20Pin), .romPin(romPin),
        .ignPin(ignPin));
    function automatic logic [19:0] maskOf(logic [2:0] s);
        if (s[2]) return 20'h00000;
        case (s[1:0])
            2'b11: return 20'h10000;
            2'b10: return 20'h20000;
            2'b01: return 20'h40000;
            default: return 20'h08000;
        endcase
    endfunction
    task test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end
    always @(posedge clk) begin
        #1;
        if (notes.size() > 0) begin
            note = notes.pop_front();
            comparisons++;
            if ({valid, a20Oe, romOe, ignOe, a20Out, romOut, addrOut, irq, ignOut} !== note) begin
                n_errors++;
                $display("unexpected outputs expected %h seen %h", note,
                         {valid, a20Oe, romOe, ignOe, a20Out, romOut, addrOut, irq, ignOut});
            end
        end
    end
    initial begin
        void'($urandom(28));
        for (int k = 7; k >= 0; k--) begin
            @(negedge clk);
            resetn = 0;
            notes.delete();
            {sM, sA, sB} = k[2:0];
            repeat (4) @(negedge clk);
            resetn = 1;
            // First edge only latches: address uninverted, processor side quiet
            notes.push_back({4'hF, a20Lvl, romLvl, addr, 2'b00});
            mask = maskOf(k[2:0]);
            @(negedge clk);
            // Strap pulls flip after the latch; the mask must not follow
            {sM, sA, sB} = ~k[2:0];
            notes.push_back({4'hF, a20Lvl, romLvl, addr ^ mask, float_error_in, ignLvl});
            repeat (12) @(negedge clk) begin
                {addr, float_error_in, ignLvl, a20Lvl, romLvl} = 24'($urandom);
                notes.push_back({4'hF, a20Lvl, romLvl, addr ^ mask, float_error_in, ignLvl});
            end
        end
        @(negedge clk);
        test_done();
    end
endmodule
